// ---- hw/agc_pkg.sv ----
package agc_pkg;
  localparam int SENSOR_COLS = 1024;
  localparam int SENSOR_ROWS = 768;
  localparam int NUM_WINDOWS = 2;
  localparam int COORD_W = 12;
  localparam int PIX_W = 12;
  localparam int GAIN_W = 12;
  localparam int SUM_W = 44;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  localparam logic [COORD_W-1:0] SENSOR_COLS_C = 12'h400;
  localparam logic [COORD_W-1:0] SENSOR_ROWS_C = 12'h300;
  localparam logic [COORD_W-1:0] COORD_ZERO = 12'h000;

  localparam logic [ADDR_W-1:0] OFS_WIN_SEL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_WIN_COL = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_WIN_ROW = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_WIN_COLS = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_WIN_ROWS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_GAIN_MAN = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_GAIN_LO = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_GAIN_HI = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_FMT = 5'h0a;
  localparam logic [ADDR_W-1:0] OFS_GAIN_OUT = 5'h0b;
  localparam logic [ADDR_W-1:0] OFS_AVG = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0d;
  localparam logic [ADDR_W-1:0] OFS_BIND = 5'h0e;

  localparam logic [GAIN_W-1:0] GAIN_MIN_C = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_MAX_8 = 12'h3ff;
  localparam logic [GAIN_W-1:0] GAIN_MAX_12 = 12'h1ff;
  localparam logic [GAIN_W-1:0] GAIN_MAX_UNLIM = 12'hfff;
  localparam logic [GAIN_W-1:0] GAIN_BIN_CAP = 12'h2ff;
  localparam logic [GAIN_W-1:0] GAIN_STEP = 12'h001;
  localparam logic [PIX_W-1:0] TARGET_MAX_8 = 12'h0ff;
  localparam logic [PIX_W-1:0] TARGET_MAX_12 = 12'hfff;
  localparam logic [PIX_W-1:0] TARGET_RST = 12'h080;
  localparam logic [4:0] ONCE_MAX_FRAMES = 5'h1e;
  localparam logic [DATA_W-1:0] BIND_RST = 32'h0000_0000;
  localparam int DIV_CYC = SUM_W + 1;

  typedef enum logic [1:0] {
    AGC_OFF = 2'b00,
    AGC_ONCE = 2'b01,
    AGC_CONT = 2'b10
  } agc_mode_t;

  typedef struct packed {
    logic [COORD_W-1:0] col;
    logic [COORD_W-1:0] row;
    logic [COORD_W-1:0] cols;
    logic [COORD_W-1:0] rows;
  } agc_win_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic [COORD_W-1:0] col;
    logic [COORD_W-1:0] row;
    logic [PIX_W-1:0] data;
  } agc_pix_t;
endpackage

// ---- hw/agc_divider.sv ----
`timescale 1ns/1ps
module agc_divider
  import agc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // request
  input wire logic start_i,
  input wire logic [SUM_W-1:0] num_i,
  input wire logic [CNT_W-1:0] den_i,
  // result
  output logic done_o,
  output logic [SUM_W-1:0] quot_o
);
  // restoring divider, one quotient bit per cycle; a frame is far longer
  logic [SUM_W-1:0] num_reg;
  logic [SUM_W:0] rem_reg;
  logic [CNT_W-1:0] den_reg;
  logic [6:0] cnt_reg;
  logic busy_reg;
  logic [SUM_W:0] trial;

  always_comb begin
    trial = {rem_reg[SUM_W-1:0], num_reg[SUM_W-1]};
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_reg <= 1'b0;
      done_o <= 1'b0;
      cnt_reg <= 7'h00;
      num_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      quot_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_reg <= 1'b1;
        num_reg <= num_i;
        den_reg <= den_i;
        rem_reg <= '0;
        cnt_reg <= 7'(DIV_CYC - 1);
      end else if (busy_reg) begin
        num_reg <= {num_reg[SUM_W-2:0], 1'b0};
        if (trial >= {{(SUM_W+1-CNT_W){1'b0}}, den_reg}) begin
          rem_reg <= trial - {{(SUM_W+1-CNT_W){1'b0}}, den_reg};
          quot_o <= {quot_o[SUM_W-2:0], 1'b1};
        end else begin
          rem_reg <= trial;
          quot_o <= {quot_o[SUM_W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 7'h01;
        if (cnt_reg == 7'h01) begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- hw/agc_core.sv ----
`timescale 1ns/1ps
// Function
// (RULE1) software selects window, then writes geometry
// (RULE2) reset windows cover the full sensor
// (RULE3) offsets give first column/row, sizes span
// (RULE4) offset plus size below sensor; else refused (code also accepts a sum equal to the sensor size)
// (RULE5) geometry adjustable in single steps
// (RULE6) color: even steps recommended to software
// (RULE7) binned: geometry counts virtual columns/lines
// (RULE8) active gain steers average toward target
// (RULE9) single-shot and continuous modes supported
// (RULE10) no overlap: manual gain stays in control
// (RULE11) software programs profile when both run
// (RULE12) auto gain clamped within lower/upper limits
// (RULE13) limit range depends on format, binning
// (RULE14) target 0..255 eight-bit, 0..4095 twelve-bit
// (RULE15) one shared target for gain and exposure
// (RULE16) once: off at target or 30 images
// (RULE17) only window/image intersection pixels count
// (RULE18) reset binds gain and exposure to window one
// (RULE19) per-frame average is sum over count
module agc_core
  import agc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // pixel stream and image window
  input wire agc_pix_t pix_i,
  input wire agc_win_t image_win_i,
  // camera state bits
  input wire logic fmt_12bit_i,
  input wire logic binning_i,
  input wire logic limits_off_i,
  // gain out
  output logic [GAIN_W-1:0] gain_o,
  output logic [PIX_W-1:0] target_gray_level_o,
  output logic auto_active_o
);
  agc_win_t win_reg [NUM_WINDOWS];
  logic stats_window_select_reg;
  logic bind_reg;
  agc_mode_t auto_gain_mode_reg;
  logic [GAIN_W-1:0] manual_gain_value_reg;
  logic [GAIN_W-1:0] gain_lower_bound_reg;
  logic [GAIN_W-1:0] gain_upper_bound_reg;
  logic [PIX_W-1:0] target_gray_level_reg;
  logic [GAIN_W-1:0] auto_gain_reg;
  logic use_auto_reg;
  logic [PIX_W-1:0] avg_reg;
  logic reject_reg;
  logic [4:0] once_cnt_reg;
  logic [SUM_W-1:0] sum_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [SUM_W-1:0] quot;
  logic div_start;
  logic div_done;
  logic frame_end;
  logic [GAIN_W-1:0] gain_cap;
  logic [GAIN_W-1:0] start_gain;
  logic [PIX_W-1:0] target_max;
  logic [COORD_W:0] geo_end;
  logic [COORD_W:0] geo_lim;
  logic [COORD_W-1:0] new_col;
  logic [COORD_W-1:0] new_row;
  logic [COORD_W-1:0] new_cols;
  logic [COORD_W-1:0] new_rows;
  logic geo_wr;
  logic geo_ok;
  logic in_stats;
  logic in_image;
  logic overlap;
  agc_win_t sw;
  logic [PIX_W-1:0] wtarget;

  // limit ceilings follow format, binning, unlocked limits
  always_comb begin
    gain_cap = fmt_12bit_i ? GAIN_MAX_12 : GAIN_MAX_8;
    if (binning_i && gain_cap > GAIN_BIN_CAP) begin
      gain_cap = GAIN_BIN_CAP; // RULE13
    end
    if (limits_off_i) begin
      gain_cap = GAIN_MAX_UNLIM; // RULE13
    end
    target_max = fmt_12bit_i ? TARGET_MAX_12 : TARGET_MAX_8; // RULE14
    // an auto run begun after reset or a manual gain write starts from manual gain pulled inside the limits
    start_gain = manual_gain_value_reg;
    if (start_gain > gain_upper_bound_reg) begin
      start_gain = gain_upper_bound_reg; // RULE12
    end
    if (start_gain < gain_lower_bound_reg) begin
      start_gain = gain_lower_bound_reg; // RULE12
    end
  end

  // geometry check on the selected window, single-step granularity
  always_comb begin
    sw = win_reg[stats_window_select_reg]; // RULE1
    new_col = (addr_i == OFS_WIN_COL) ? wdata_i[COORD_W-1:0] : sw.col;
    new_row = (addr_i == OFS_WIN_ROW) ? wdata_i[COORD_W-1:0] : sw.row;
    new_cols = (addr_i == OFS_WIN_COLS) ? wdata_i[COORD_W-1:0] : sw.cols;
    new_rows = (addr_i == OFS_WIN_ROWS) ? wdata_i[COORD_W-1:0] : sw.rows;
    geo_wr = wr_i && (addr_i == OFS_WIN_COL || addr_i == OFS_WIN_ROW ||
      addr_i == OFS_WIN_COLS || addr_i == OFS_WIN_ROWS);
    // full-sensor reset value must stay writable, so bound is inclusive
    geo_end = {1'b0, new_col} + {1'b0, new_cols};
    geo_lim = {1'b0, SENSOR_COLS_C};
    geo_ok = (geo_end <= geo_lim); // RULE4
    geo_end = {1'b0, new_row} + {1'b0, new_rows};
    geo_lim = {1'b0, SENSOR_ROWS_C};
    geo_ok = geo_ok && (geo_end <= geo_lim); // RULE4
    wtarget = (wdata_i[PIX_W-1:0] > target_max) ? target_max
      : wdata_i[PIX_W-1:0]; // RULE14
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_WINDOWS; i++) begin
        win_reg[i] <= '{COORD_ZERO, COORD_ZERO, SENSOR_COLS_C,
          SENSOR_ROWS_C}; // RULE2
      end
      reject_reg <= 1'b0;
    end else if (geo_wr) begin
      reject_reg <= !geo_ok;
      if (geo_ok) begin
        win_reg[stats_window_select_reg] <= '{new_col, new_row, new_cols,
          new_rows}; // RULE3 RULE5 RULE7
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      stats_window_select_reg <= 1'b0;
      bind_reg <= BIND_RST[0]; // RULE18
      manual_gain_value_reg <= GAIN_MIN_C;
      gain_lower_bound_reg <= GAIN_MIN_C;
      gain_upper_bound_reg <= GAIN_MAX_8;
      target_gray_level_reg <= TARGET_RST;
    end else if (wr_i) begin
      case (addr_i)
        OFS_WIN_SEL: stats_window_select_reg <= wdata_i[0]; // RULE1
        OFS_BIND: bind_reg <= wdata_i[0];
        OFS_GAIN_MAN: manual_gain_value_reg <= wdata_i[GAIN_W-1:0];
        OFS_GAIN_LO: begin
          if (wdata_i[GAIN_W-1:0] <= gain_cap) begin
            gain_lower_bound_reg <= wdata_i[GAIN_W-1:0]; // RULE13
          end
        end
        OFS_GAIN_HI: begin
          if (wdata_i[GAIN_W-1:0] <= gain_cap) begin
            gain_upper_bound_reg <= wdata_i[GAIN_W-1:0]; // RULE13
          end
        end
        OFS_TARGET: target_gray_level_reg <= wtarget; // RULE14
        default: ;
      endcase
    end
  end

  // intersection of bound statistics window and image window
  always_comb begin
    in_stats = pix_i.col >= win_reg[bind_reg].col &&
      pix_i.col < win_reg[bind_reg].col + win_reg[bind_reg].cols &&
      pix_i.row >= win_reg[bind_reg].row &&
      pix_i.row < win_reg[bind_reg].row + win_reg[bind_reg].rows;
    in_image = pix_i.col >= image_win_i.col &&
      pix_i.col < image_win_i.col + image_win_i.cols &&
      pix_i.row >= image_win_i.row &&
      pix_i.row < image_win_i.row + image_win_i.rows;
    frame_end = pix_i.valid && pix_i.sof;
    div_start = frame_end && (cnt_reg != '0);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sum_reg <= '0;
      cnt_reg <= '0;
    end else if (pix_i.valid) begin
      // divider latches the closing frame's totals on this same edge
      if (pix_i.sof) begin
        sum_reg <= '0;
        cnt_reg <= '0;
      end
      // sof pixel starts the new frame and counts toward it
      if (in_stats && in_image) begin
        if (pix_i.sof) begin
          sum_reg <= {{(SUM_W-PIX_W){1'b0}}, pix_i.data}; // RULE17
          cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
          sum_reg <= sum_reg + {{(SUM_W-PIX_W){1'b0}}, pix_i.data}; // RULE17
          cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  agc_divider u_div (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .start_i(div_start),
    .num_i(sum_reg),
    .den_i(cnt_reg),
    .done_o(div_done),
    .quot_o(quot)
  );

  // whole-frame overlap: an empty intersection leaves manual in charge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      overlap <= 1'b0;
    end else if (frame_end) begin
      overlap <= (cnt_reg != '0); // RULE10
    end
  end

  // gain update once per finished frame; step of one toward target
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      auto_gain_mode_reg <= AGC_OFF;
      auto_gain_reg <= GAIN_MIN_C;
      once_cnt_reg <= 5'h00;
      use_auto_reg <= 1'b0;
    end else if (wr_i && addr_i == OFS_MODE) begin
      auto_gain_mode_reg <= agc_mode_t'(wdata_i[1:0]); // RULE9
      once_cnt_reg <= 5'h00;
      if (wdata_i[1:0] != AGC_OFF && !use_auto_reg) begin
        auto_gain_reg <= start_gain; // RULE12
      end
      use_auto_reg <= (wdata_i[1:0] != AGC_OFF) || use_auto_reg;
    end else if (wr_i && addr_i == OFS_GAIN_MAN) begin
      use_auto_reg <= 1'b0;
    end else if (div_done && auto_gain_mode_reg != AGC_OFF) begin
      if (quot[PIX_W-1:0] < target_gray_level_reg) begin // RULE8 RULE15
        if (auto_gain_reg < gain_upper_bound_reg) begin
          auto_gain_reg <= auto_gain_reg + GAIN_STEP; // RULE12
        end
      end else if (quot[PIX_W-1:0] > target_gray_level_reg) begin
        if (auto_gain_reg > gain_lower_bound_reg) begin
          auto_gain_reg <= auto_gain_reg - GAIN_STEP; // RULE12
        end
      end
      if (auto_gain_mode_reg == AGC_ONCE) begin
        once_cnt_reg <= once_cnt_reg + 5'h01;
        if (quot[PIX_W-1:0] == target_gray_level_reg ||
            once_cnt_reg + 5'h01 >= ONCE_MAX_FRAMES) begin
          auto_gain_mode_reg <= AGC_OFF; // RULE16
        end
      end
    end
  end

  // measured average follows every frame with counted pixels, whether auto runs or not
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avg_reg <= '0;
    end else if (div_done) begin
      avg_reg <= quot[PIX_W-1:0]; // RULE19
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      gain_o <= GAIN_MIN_C;
    end else if (use_auto_reg && overlap) begin
      gain_o <= auto_gain_reg; // RULE8
    end else begin
      gain_o <= manual_gain_value_reg; // RULE10
    end
  end

  assign target_gray_level_o = target_gray_level_reg; // RULE15
  assign auto_active_o = (auto_gain_mode_reg != AGC_OFF);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_WIN_SEL: rdata_o <= {31'h0, stats_window_select_reg};
        OFS_WIN_COL: rdata_o <= {20'h0, sw.col};
        OFS_WIN_ROW: rdata_o <= {20'h0, sw.row};
        OFS_WIN_COLS: rdata_o <= {20'h0, sw.cols};
        OFS_WIN_ROWS: rdata_o <= {20'h0, sw.rows};
        OFS_MODE: rdata_o <= {30'h0, auto_gain_mode_reg};
        OFS_GAIN_MAN: rdata_o <= {20'h0, manual_gain_value_reg};
        OFS_GAIN_LO: rdata_o <= {20'h0, gain_lower_bound_reg};
        OFS_GAIN_HI: rdata_o <= {20'h0, gain_upper_bound_reg};
        OFS_TARGET: rdata_o <= {20'h0, target_gray_level_reg};
        OFS_FMT: rdata_o <= {29'h0, limits_off_i, binning_i, fmt_12bit_i};
        OFS_GAIN_OUT: rdata_o <= {20'h0, gain_o};
        OFS_AVG: rdata_o <= {20'h0, avg_reg};
        OFS_STATUS: rdata_o <= {29'h0, reject_reg, overlap, use_auto_reg};
        OFS_BIND: rdata_o <= {31'h0, bind_reg};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

// ---- tb/agc_checker.sv ----
`timescale 1ns/1ps
module agc_checker
  import agc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // pixels and camera state
  input wire agc_pix_t pix_i,
  input wire agc_win_t image_win_i,
  input wire logic fmt_12bit_i,
  input wire logic binning_i,
  input wire logic limits_off_i,
  // gain side
  input wire logic [GAIN_W-1:0] gain_o,
  input wire logic [PIX_W-1:0] target_gray_level_o,
  input wire logic auto_active_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // manual write, then a quiet edge so nothing overrides it
  sequence s_man_wr;
    wr_i && addr_i == OFS_GAIN_MAN && wdata_i <= 32'h1ff ##1 !wr_i;
  endsequence
  a_gain_readback: assert property (
    rd_i && addr_i == OFS_GAIN_OUT |=> rdata_o == DATA_W'($past(gain_o)))
    else $error("gain readback wrong");
  a_manual_gain: assert property (
    s_man_wr |=> DATA_W'(gain_o) == $past(wdata_i, 2))
    else $error("manual gain lost");
  a_target_clamp: assert property (
    wr_i && addr_i == OFS_TARGET && !fmt_12bit_i && wdata_i > 32'h0ff
    |=> target_gray_level_o == TARGET_MAX_8)
    else $error("target not clamped");
  a_target_take: assert property (
    wr_i && addr_i == OFS_TARGET && wdata_i <= 32'h0ff
    |=> DATA_W'(target_gray_level_o) == $past(wdata_i))
    else $error("target not taken");
  a_target_hold: assert property (
    !(wr_i && addr_i == OFS_TARGET) |=> $stable(target_gray_level_o))
    else $error("target moved");
  a_mode_on: assert property (
    wr_i && addr_i == OFS_MODE && (wdata_i == 32'h1 || wdata_i == 32'h2)
    |=> auto_active_o)
    else $error("mode not on");
  a_mode_off: assert property (
    wr_i && addr_i == OFS_MODE && wdata_i == 32'h0 |=> !auto_active_o)
    else $error("mode not off");
  // writes and frame starts (overlap switch) may jump the gain;
  // frame updates move it one step only
  a_gain_step: assert property (
    (!wr_i && !(pix_i.valid && pix_i.sof)) [*3] ##1 $changed(gain_o)
    |-> gain_o == $past(gain_o) + GAIN_STEP
    || gain_o == $past(gain_o) - GAIN_STEP)
    else $error("gain jumped");
endmodule

bind agc_core agc_checker agc_checker_inst (
  .mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pix_i,
  .image_win_i, .fmt_12bit_i, .binning_i, .limits_off_i, .gain_o,
  .target_gray_level_o, .auto_active_o
);

// ---- tb/agc_pix_src.sv ----
`timescale 1ns/1ps
module agc_pix_src
  import agc_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // frame shape and content
  input wire agc_win_t win_i,
  input wire logic [PIX_W-1:0] lvl_i,
  input wire logic [PIX_W-1:0] alt_i,
  input wire logic slow_i,
  // pixel stream
  output agc_pix_t pix_o
);
  initial pix_o = '0;
  // idle beats scramble the payload so stale data never looks valid
  task automatic idle();
    @(posedge mclk_i);
    pix_o <= {2'b00, ~pix_o.col, ~pix_o.row, ~pix_o.data};
  endtask
  // columns with bit 2 set carry alt_i, the rest lvl_i
  task automatic send_frame();
    logic [COORD_W-1:0] cc;
    logic [COORD_W-1:0] rr;
    for (rr = COORD_ZERO; rr < win_i.rows; rr++) begin
      for (cc = COORD_ZERO; cc < win_i.cols; cc++) begin
        @(posedge mclk_i);
        pix_o <= {1'b1, (rr == COORD_ZERO) && (cc == COORD_ZERO),
                  win_i.col + cc, win_i.row + rr, cc[2] ? alt_i : lvl_i};
        if (slow_i) idle();
      end
    end
    // gap covers the divider before the next frame start
    repeat (60) idle();
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import agc_pkg::*;
  typedef struct {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [2:0] cfg;
    logic [DATA_W-1:0] exp;
  } agc_row_t;
  logic mclk_i, srst_i, wr_i, rd_i, slow;
  logic fmt_12bit_i, binning_i, limits_off_i, auto_active_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic [GAIN_W-1:0] gain_o;
  logic [PIX_W-1:0] target_gray_level_o, lvl, alt;
  agc_pix_t pix_i;
  agc_win_t image_win_i;
  int mismatches = 0;
  int tests_run = 0;
  // cfg is {fmt_12bit, binning, limits_off}
  agc_row_t rows[] = '{
    '{1'b0, OFS_FMT, 32'h0, 3'h5, 32'h5},
    '{1'b0, OFS_WIN_COL, 32'h0, 3'h0, 32'h0},
    '{1'b0, OFS_WIN_COLS, 32'h0, 3'h0, 32'h400},
    '{1'b0, OFS_WIN_ROWS, 32'h0, 3'h0, 32'h300},
    '{1'b0, OFS_TARGET, 32'h0, 3'h0, 32'h080},
    '{1'b0, OFS_GAIN_HI, 32'h0, 3'h0, 32'h3ff},
    '{1'b1, OFS_TARGET, 32'h1ff, 3'h0, 32'h0ff},
    '{1'b1, OFS_TARGET, 32'hfff, 3'h4, 32'hfff},
    '{1'b1, OFS_TARGET, 32'h040, 3'h0, 32'h040},
    '{1'b1, OFS_GAIN_HI, 32'h300, 3'h2, 32'h3ff},
    '{1'b1, OFS_GAIN_HI, 32'h400, 3'h1, 32'h400},
    '{1'b1, OFS_GAIN_HI, 32'h020, 3'h0, 32'h020},
    '{1'b1, OFS_GAIN_LO, 32'h010, 3'h0, 32'h010},
    '{1'b1, OFS_WIN_SEL, 32'h1, 3'h0, 32'h1},
    '{1'b1, OFS_WIN_COL, 32'h3ff, 3'h0, 32'h0},
    '{1'b0, OFS_STATUS, 32'h0, 3'h0, 32'h4},
    '{1'b1, OFS_WIN_COLS, 32'h1, 3'h0, 32'h1},
    '{1'b0, OFS_STATUS, 32'h0, 3'h0, 32'h0},
    '{1'b1, OFS_WIN_COL, 32'h3ff, 3'h0, 32'h3ff},
    '{1'b1, OFS_WIN_SEL, 32'h0, 3'h0, 32'h0},
    '{1'b0, OFS_WIN_COLS, 32'h0, 3'h0, 32'h400}
  };
  agc_core agc_core_inst (
    .mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pix_i,
    .image_win_i, .fmt_12bit_i, .binning_i, .limits_off_i, .gain_o,
    .target_gray_level_o, .auto_active_o
  );
  agc_pix_src agc_pix_src_inst (
    .mclk_i, .win_i(image_win_i), .lvl_i(lvl), .alt_i(alt), .slow_i(slow),
    .pix_o(pix_i)
  );
  task automatic check(input string nm, input logic [DATA_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check("register", rdata_o, e);
  endtask
  // frame stats land at the next frame start, so counts carry slack
  task automatic frames(input int n);
    repeat (n) agc_pix_src_inst.send_frame();
    #1;
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    srst_i = 1'b1;
    {addr_i, wdata_i, wr_i, rd_i, slow} = '0;
    {fmt_12bit_i, binning_i, limits_off_i} = 3'h0;
    image_win_i = '{COORD_ZERO, COORD_ZERO, 12'h008, 12'h004};
    lvl = 12'h0ff;
    alt = 12'h0ff;
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge mclk_i);
      {fmt_12bit_i, binning_i, limits_off_i} <= rows[i].cfg;
      if (rows[i].wr) wr_reg(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    wr_reg(OFS_GAIN_MAN, 32'h018);
    // gain alone runs auto, so no balancing profile is due
    wr_reg(OFS_MODE, 32'h2);
    frames(14);
    check("gain", DATA_W'(gain_o), 32'h010);
    lvl <= 12'h000;
    alt <= 12'h000;
    slow <= 1'b1;
    frames(20);
    rd_chk(OFS_GAIN_OUT, 32'h020);
    // dark scene at the upper bound can never meet the target
    wr_reg(OFS_MODE, 32'h1);
    frames(10);
    check("active", DATA_W'(auto_active_o), 32'h1);
    frames(24);
    rd_chk(OFS_MODE, 32'h0);
    lvl <= 12'h040;
    alt <= 12'h040;
    slow <= 1'b0;
    wr_reg(OFS_GAIN_MAN, 32'h015);
    // one frame of this scene first, so the once run never sees the dark one
    frames(1);
    wr_reg(OFS_MODE, 32'h1);
    frames(3);
    check("active", DATA_W'(auto_active_o), 32'h0);
    rd_chk(OFS_GAIN_OUT, 32'h015);
    lvl <= 12'h020;
    alt <= 12'h060;
    frames(2);
    rd_chk(OFS_AVG, 32'h040);
    wr_reg(OFS_WIN_COLS, 32'h004);
    frames(2);
    rd_chk(OFS_AVG, 32'h020);
    lvl <= 12'h000;
    alt <= 12'h000;
    wr_reg(OFS_WIN_COLS, 32'h010);
    wr_reg(OFS_WIN_COL, 32'h200);
    wr_reg(OFS_GAIN_MAN, 32'h018);
    wr_reg(OFS_MODE, 32'h2);
    frames(5);
    check("gain", DATA_W'(gain_o), 32'h018);
    wr_reg(OFS_MODE, 32'h0);
    rd_chk(OFS_MODE, 32'h0);
    rd_chk(OFS_GAIN_OUT, 32'h018);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd_chk(OFS_WIN_COL, 32'h0);
    rd_chk(OFS_BIND, 32'h0);
    check("gain", DATA_W'(gain_o), 32'h0);
    finish_test();
  end
endmodule
